// *** lds_pkg.sv ***
/*
  Shared constants and state types for the lamp dimmer two-wire slave and
  register bank. Assumes a 20 MHz system clock and a separate link clock.
*/
package lds_pkg;
  // Bus address and register indexes.
  localparam logic [6:0] SLAVE_ADDR = 7'h2C;
  localparam logic [7:0] REG_LAST = 8'h06;
  localparam logic [2:0] REG_BRI = 3'h0;
  localparam logic [2:0] REG_CTRL = 3'h1;
  localparam logic [2:0] REG_STAT = 3'h2;
  localparam logic [2:0] REG_ID = 3'h3;
  localparam logic [2:0] REG_AMB = 3'h4;
  localparam logic [2:0] REG_FLOOR = 3'h5;
  localparam logic [2:0] REG_CEIL = 3'h6;
  // Reset values.
  localparam logic [7:0] BRI_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FLOOR_RST = 8'h00;
  localparam logic [7:0] CEIL_RST = 8'hFF;
  // Control and status field positions.
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_SRC_BIT = 1;
  localparam int CTL_PWM_INTERP_BIT = 2;
  localparam int CTL_SENSOR_SEL_BIT = 3;
  localparam int CTL_DEL_LO_BIT = 4;
  localparam int CTL_DEL_HI_BIT = 5;
  localparam logic [7:0] CTRL_WR_MASK = 8'h3F;
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_OVC_BIT = 2;
  localparam int ST_LAMP_BIT = 3;
  // Ambient delay: periods per delay code and the period length.
  localparam logic [2:0] DEL_N_00 = 3'h4;
  localparam logic [2:0] DEL_N_01 = 3'h2;
  localparam logic [2:0] DEL_N_10 = 3'h3;
  localparam logic [2:0] DEL_N_11 = 3'h5;
  localparam int CLK_SYS_KHZ = 20000;
  localparam int AMB_PERIOD_MS = 5;
  localparam int AMB_PERIOD_CYC = AMB_PERIOD_MS * CLK_SYS_KHZ;
  localparam int AMB_CNT_W = 20;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_DATA, ST_DATA_ACK, ST_RD
  } lds_state_type;

  typedef struct packed {
    logic [7:0] bri_host;
    logic [7:0] ctrl;
    logic [7:0] floor_lim;
    logic [7:0] ceil_lim;
    logic [7:0] amb_rd;
    logic [7:0] amb_cur;
    logic [7:0] bri_eff;
    logic fault;
    logic ovc;
    logic [AMB_CNT_W-1:0] per_cnt;
    logic [2:0] per_num;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic ack_s1;
    logic ack_s2;
    logic snap_tgl;
    logic [7:0][7:0] snap;
  } lds_sys_type;

  typedef struct packed {
    lds_state_type state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic rw;
    logic [2:0] ptr;
    logic [2:0] wcmd;
    logic [7:0] wdata;
    logic pend;
    logic wr_tgl;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic sda_oe;
    logic snap_s1;
    logic snap_s2;
    logic ack_tgl;
    logic [7:0][7:0] rd_bank;
  } lds_link_type;

  localparam lds_sys_type SYS_RST = '{bri_host: BRI_RST, ctrl: CTRL_RST, floor_lim: FLOOR_RST,
    ceil_lim: CEIL_RST, default: '0};
  localparam lds_link_type LINK_RST = '{state: ST_IDLE, default: '0};
endpackage : lds_pkg

// *** lds_slave_regs.sv ***
/*
  Two-wire slave front end, register bank and brightness source selection
  for a lamp inverter. The bus engine runs on clk_link_in and oversamples
  scl/sda; registers and brightness logic run on clk_sys_in. Assumes scl is
  at least eight times slower than clk_link_in and an external open-drain pad.
*/
`timescale 1ns/1ps
module lds_slave_regs
  import lds_pkg::*;
#(
  parameter int AMB_PERIOD_CYCLES = AMB_PERIOD_CYC,
  parameter logic [4:0] VENDOR_FIELD = 5'h0A, // Arbitrary value.
  parameter logic [2:0] REVISION = 3'h2 // Arbitrary value.
)
(
  // System clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Link pins
  input wire logic clk_link_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Inverter side
  input wire logic [7:0] pwm_duty_in,
  input wire logic [7:0] ambient_reading_in,
  input wire logic lamp_fault_in,
  input wire logic overcurrent_in,
  input wire logic lamps_on_in,
  output logic lamp_enable_out,
  output logic sensor_supply_out,
  output logic [7:0] brightness_out
);
  lds_sys_type s_reg;
  lds_sys_type s_next;
  lds_link_type l_reg;
  lds_link_type l_next;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic commit;
  logic host_mode;
  logic pwm_mode;

  assign start_det = l_reg.scl_s2 & l_reg.scl_s3 & l_reg.sda_s3 & ~l_reg.sda_s2;
  assign stop_det = l_reg.scl_s2 & l_reg.scl_s3 & ~l_reg.sda_s3 & l_reg.sda_s2;
  assign scl_rise = l_reg.scl_s2 & ~l_reg.scl_s3;
  assign scl_fall = ~l_reg.scl_s2 & l_reg.scl_s3;
  assign commit = s_reg.wr_s2 ^ s_reg.wr_s3;
  assign host_mode = ~s_reg.ctrl[CTL_SENSOR_SEL_BIT] & ~s_reg.ctrl[CTL_SRC_BIT];
  assign pwm_mode = ~s_reg.ctrl[CTL_SENSOR_SEL_BIT] & s_reg.ctrl[CTL_SRC_BIT];

  // Scales a base code by duty; a duty of 0xFF passes the base unchanged.
  function automatic logic [7:0] scale(input logic [7:0] base, input logic [7:0] duty);
    logic [16:0] prod;
    prod = base * ({1'b0, duty} + 9'h001);
    return prod[15:8];
  endfunction : scale

  // Link domain: bus engine.
  always_comb
  begin
    l_next = l_reg;
    l_next.scl_s1 = scl_in;
    l_next.scl_s2 = l_reg.scl_s1;
    l_next.scl_s3 = l_reg.scl_s2;
    l_next.sda_s1 = sda_in;
    l_next.sda_s2 = l_reg.sda_s1;
    l_next.sda_s3 = l_reg.sda_s2;
    // The read bank is copied only while the system side holds its snapshot still.
    l_next.snap_s1 = s_reg.snap_tgl;
    l_next.snap_s2 = l_reg.snap_s1;
    if (l_reg.snap_s2 != l_reg.ack_tgl)
    begin
      l_next.rd_bank = s_reg.snap;
      l_next.ack_tgl = l_reg.snap_s2;
    end
    if (start_det || stop_det)
    begin
      if (l_reg.pend)
      begin
        l_next.wr_tgl = ~l_reg.wr_tgl;
      end
      l_next.pend = 1'b0;
      l_next.sda_oe = 1'b0;
      l_next.bitcnt = 4'h0;
      l_next.state = start_det ? ST_ADDR : ST_IDLE;
    end
    else
    begin
      if (scl_rise && l_reg.bitcnt < 4'h8 &&
          (l_reg.state == ST_ADDR || l_reg.state == ST_CMD || l_reg.state == ST_DATA))
      begin
        l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
        l_next.bitcnt = l_reg.bitcnt + 4'h1;
      end
      if (scl_fall)
      begin
        unique case (l_reg.state)
          ST_IDLE:
          begin
          end
          ST_ADDR:
          begin
            if (l_reg.bitcnt == 4'h8)
            begin
              l_next.bitcnt = 4'h0;
              if (l_reg.shift[7:1] == SLAVE_ADDR)
              begin
                l_next.rw = l_reg.shift[0];
                l_next.state = ST_ADDR_ACK;
                l_next.sda_oe = 1'b1;
              end
              else
              begin
                l_next.state = ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK:
          begin
            if (l_reg.rw)
            begin
              l_next.shift = l_reg.rd_bank[l_reg.ptr];
              l_next.sda_oe = ~l_reg.rd_bank[l_reg.ptr][7];
              l_next.bitcnt = 4'h0;
              l_next.state = ST_RD;
            end
            else
            begin
              l_next.sda_oe = 1'b0;
              l_next.state = ST_CMD;
            end
          end
          ST_CMD:
          begin
            if (l_reg.bitcnt == 4'h8)
            begin
              l_next.bitcnt = 4'h0;
              if (l_reg.shift <= REG_LAST)
              begin
                l_next.ptr = l_reg.shift[2:0];
                l_next.state = ST_CMD_ACK;
                l_next.sda_oe = 1'b1;
              end
              else
              begin
                l_next.state = ST_IDLE;
              end
            end
          end
          ST_CMD_ACK:
          begin
            l_next.sda_oe = 1'b0;
            l_next.state = ST_DATA;
          end
          ST_DATA:
          begin
            if (l_reg.bitcnt == 4'h8)
            begin
              l_next.bitcnt = 4'h0;
              l_next.wdata = l_reg.shift;
              l_next.wcmd = l_reg.ptr;
              l_next.state = ST_DATA_ACK;
              l_next.sda_oe = 1'b1;
            end
          end
          ST_DATA_ACK:
          begin
            // Only now is the byte complete; further bytes are not acknowledged.
            l_next.sda_oe = 1'b0;
            l_next.pend = 1'b1;
            l_next.state = ST_IDLE;
          end
          ST_RD:
          begin
            l_next.bitcnt = l_reg.bitcnt + 4'h1;
            if (l_reg.bitcnt == 4'h7)
            begin
              l_next.sda_oe = 1'b0;
              l_next.state = ST_IDLE;
            end
            else
            begin
              l_next.shift = {l_reg.shift[6:0], 1'b0};
              l_next.sda_oe = ~l_reg.shift[6];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_link_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      l_reg <= LINK_RST;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // System domain: registers and brightness selection.
  always_comb
  begin
    logic [7:0] amb_base;
    logic [7:0] eff;
    logic [2:0] del_n;
    amb_base = 8'h00;
    eff = 8'h00;
    del_n = DEL_N_00;
    s_next = s_reg;
    s_next.wr_s1 = l_reg.wr_tgl;
    s_next.wr_s2 = s_reg.wr_s1;
    s_next.wr_s3 = s_reg.wr_s2;
    s_next.ack_s1 = l_reg.ack_tgl;
    s_next.ack_s2 = s_reg.ack_s1;
    s_next.amb_rd = ambient_reading_in;
    // Set wins over the shutdown clear so a fault in that cycle is not lost.
    s_next.fault = lamp_fault_in | (s_reg.fault & s_reg.ctrl[CTL_EN_BIT]);
    s_next.ovc = overcurrent_in | (s_reg.ovc & s_reg.ctrl[CTL_EN_BIT]);
    // Commits are not gated by the enable bit, so shutdown keeps the bank writable.
    if (commit)
    begin
      unique case (l_reg.wcmd)
        REG_BRI:
          if (host_mode)
            s_next.bri_host = l_reg.wdata;
        REG_CTRL:
          s_next.ctrl = l_reg.wdata & CTRL_WR_MASK;
        REG_FLOOR:
          s_next.floor_lim = l_reg.wdata;
        REG_CEIL:
          s_next.ceil_lim = l_reg.wdata;
        // Status, identification and ambient reading are read only.
        default: ;
      endcase
    end
    unique case ({s_reg.ctrl[CTL_DEL_HI_BIT], s_reg.ctrl[CTL_DEL_LO_BIT]})
      2'b11: del_n = DEL_N_11;
      2'b10: del_n = DEL_N_10;
      2'b01: del_n = DEL_N_01;
      2'b00: del_n = DEL_N_00;
    endcase
    // The delayed reading takes the live one the selected number of periods after they first differ.
    if (s_reg.amb_cur == s_reg.amb_rd)
    begin
      s_next.per_cnt = '0;
      s_next.per_num = 3'h0;
    end
    else if (s_reg.per_cnt == AMB_CNT_W'(AMB_PERIOD_CYCLES - 1))
    begin
      s_next.per_cnt = '0;
      if (s_reg.per_num == del_n - 3'h1)
      begin
        s_next.amb_cur = s_reg.amb_rd;
        s_next.per_num = 3'h0;
      end
      else
      begin
        s_next.per_num = s_reg.per_num + 3'h1;
      end
    end
    else
    begin
      s_next.per_cnt = s_reg.per_cnt + AMB_CNT_W'(1);
    end
    // Limits clamp the delayed reading directly, so a new limit acts at once.
    if (s_reg.amb_cur < s_reg.floor_lim)
      amb_base = s_reg.floor_lim;
    else if (s_reg.amb_cur > s_reg.ceil_lim)
      amb_base = s_reg.ceil_lim;
    else
      amb_base = s_reg.amb_cur;
    if (s_reg.ctrl[CTL_SENSOR_SEL_BIT])
    begin
      eff = s_reg.ctrl[CTL_PWM_INTERP_BIT] ? amb_base : scale(amb_base, pwm_duty_in);
    end
    else if (s_reg.ctrl[CTL_SRC_BIT])
    begin
      eff = pwm_duty_in;
    end
    else
    begin
      eff = s_reg.ctrl[CTL_PWM_INTERP_BIT] ? s_reg.bri_host : scale(s_reg.bri_host, pwm_duty_in);
    end
    s_next.bri_eff = eff;
    // Snapshot reloads only after the link side has taken the previous one.
    if (s_reg.ack_s2 == s_reg.snap_tgl)
    begin
      s_next.snap[REG_BRI] = host_mode ? s_reg.bri_host : s_reg.bri_eff;
      s_next.snap[REG_CTRL] = s_reg.ctrl;
      s_next.snap[REG_STAT] = {4'h0, lamps_on_in, s_reg.ovc, 1'b0, s_reg.fault};
      s_next.snap[REG_ID] = {VENDOR_FIELD, REVISION};
      s_next.snap[REG_AMB] = s_reg.amb_rd;
      s_next.snap[REG_FLOOR] = s_reg.floor_lim;
      s_next.snap[REG_CEIL] = s_reg.ceil_lim;
      s_next.snap[7] = 8'h00;
      s_next.snap_tgl = ~s_reg.snap_tgl;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_reg <= SYS_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = l_reg.sda_oe;
  assign lamp_enable_out = s_reg.ctrl[CTL_EN_BIT];
  assign sensor_supply_out = s_reg.ctrl[CTL_EN_BIT];
  assign brightness_out = s_reg.bri_eff;

  sequence s_end_pending;
    (start_det || stop_det) && l_reg.pend;
  endsequence
  sequence s_end_in_data;
    (start_det || stop_det) && l_reg.state == ST_DATA;
  endsequence
  sequence s_ctrl_commit;
    commit && l_reg.wcmd == REG_CTRL;
  endsequence

  a_addr_match: assert property (@(posedge clk_link_in) disable iff (!rst_b_in)
    l_reg.state == ST_ADDR_ACK |-> l_reg.shift[7:1] == SLAVE_ADDR)
    else $error("acknowledged a foreign address");
  a_cmd_range: assert property (@(posedge clk_link_in) disable iff (!rst_b_in)
    l_reg.state == ST_CMD_ACK |-> l_reg.shift <= REG_LAST && l_reg.ptr == l_reg.shift[2:0])
    else $error("acknowledged an unimplemented command");
  a_idle_release: assert property (@(posedge clk_link_in) disable iff (!rst_b_in)
    l_reg.state == ST_IDLE |-> !sda_oe_out)
    else $error("data line driven while idle");
  a_commit_end: assert property (@(posedge clk_link_in) disable iff (!rst_b_in)
    s_end_pending |=> l_reg.wr_tgl != $past(l_reg.wr_tgl) ##1 $stable(l_reg.wr_tgl))
    else $error("completed write not committed at end of transfer");
  a_discard_early: assert property (@(posedge clk_link_in) disable iff (!rst_b_in)
    s_end_in_data |=> !l_reg.pend && $stable(l_reg.wr_tgl))
    else $error("incomplete write was kept");
  a_host_ignore: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    commit && l_reg.wcmd == REG_BRI && !host_mode |=> $stable(s_reg.bri_host))
    else $error("brightness written outside host mode");
  a_enable_write: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    s_ctrl_commit |=> lamp_enable_out == $past(l_reg.wdata[0]) && sensor_supply_out == lamp_enable_out)
    else $error("enable or sensor supply did not follow control write");
  a_fault_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !lamp_enable_out && !lamp_fault_in |=> !s_reg.fault)
    else $error("fault latch held in shutdown");
  a_pwm_absolute: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    pwm_mode |=> brightness_out == $past(pwm_duty_in))
    else $error("PWM mode brightness differs from duty");
  a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    s_reg.snap[REG_CTRL][7:6] == 2'b00 && s_reg.snap[REG_STAT][7:4] == 4'h0 && !s_reg.snap[REG_STAT][1])
    else $error("reserved bit reads as one");
endmodule : lds_slave_regs

// *** lds_host_model.sv ***
/*
  Behavioural host controller that masters the two-wire bus by bit-banging.
  Assumes a pull-up on the data line outside this model and a free link clock.
*/
`timescale 1ns/1ps
module lds_host_model
#(
  parameter int QTR = 4
)
(
  // Link clock
  input wire logic clk_link_in,
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // The bus clock stands high between frames; it only moves inside these tasks.
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic tick();
    repeat (QTR) @(posedge clk_link_in);
  endtask : tick

  task automatic bus_start();
    @(posedge clk_link_in);
    sda_oe_out <= 1'b0;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_oe_out <= 1'b1;
    tick();
    scl_out <= 1'b0;
    tick();
  endtask : bus_start

  task automatic bus_stop();
    sda_oe_out <= 1'b1;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_oe_out <= 1'b0;
    tick();
  endtask : bus_stop

  // Data moves a full phase after the clock falls, so it never races the rise.
  task automatic bus_bit(input logic tx, output logic rx);
    sda_oe_out <= ~tx;
    tick();
    scl_out <= 1'b1;
    tick();
    rx = sda_in;
    tick();
    scl_out <= 1'b0;
    tick();
  endtask : bus_bit

  // The ninth clock is always released so the other party can acknowledge.
  task automatic bus_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bus_bit(tx[i], rx[i]);
    end
    bus_bit(1'b1, r);
    ack = ~r;
  endtask : bus_byte
endmodule : lds_host_model

// *** lds_slave_regs_tb_top.sv ***
/*
  Self-checking bench for the lamp dimmer two-wire slave and register bank.
  Assumes the host model masters the bus and a pull-up holds released lines high.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lds_slave_regs_tb_top;
  import lds_pkg::*;
  localparam int PER = 8;
  logic clk_sys_in = 1'b0;
  logic clk_link_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] duty = 8'hFF;
  logic [7:0] amb = 8'h00;
  logic fault = 1'b0;
  logic ovc = 1'b0;
  logic lamps = 1'b1;
  logic scl;
  logic host_oe;
  logic dut_oe;
  logic sda;
  logic en_out;
  logic supply_out;
  logic [7:0] bri_out;
  logic [7:0] rd;
  logic [7:0] b;
  logic [7:0] d;
  logic [7:0] a;
  logic [7:0] flo = FLOOR_RST;
  logic [7:0] cei = CEIL_RST;
  logic [7:0] rv [7];
  logic [2:0] ak;
  logic r;
  int nper [4] = '{4, 2, 3, 5};
  int n_errors = 0;
  int compares = 0;
  int seed = 79;

  // Open-drain data line with a pull-up: low whenever either party pulls it.
  assign sda = (host_oe || dut_oe) ? 1'b0 : 1'b1;

  initial
  begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  initial
  begin
    #13;
    forever #40 clk_link_in = ~clk_link_in;
  end

  // A short ambient period keeps smoothing delays short; vendor and revision are arbitrary.
  lds_slave_regs #(.AMB_PERIOD_CYCLES(PER), .VENDOR_FIELD(5'h13), .REVISION(3'h5)) i_lds_slave_regs (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .clk_link_in(clk_link_in),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(),
    .sda_oe_out(dut_oe),
    .pwm_duty_in(duty),
    .ambient_reading_in(amb),
    .lamp_fault_in(fault),
    .overcurrent_in(ovc),
    .lamps_on_in(lamps),
    .lamp_enable_out(en_out),
    .sensor_supply_out(supply_out),
    .brightness_out(bri_out)
  );

  lds_host_model i_lds_host_model (
    .clk_link_in(clk_link_in),
    .sda_in(sda),
    .scl_out(scl),
    .sda_oe_out(host_oe)
  );

  function automatic logic [7:0] scale(input logic [7:0] bv, input logic [7:0] dv);
    logic [15:0] p;
    p = {8'h00, bv} * ({8'h00, dv} + 16'h0001);
    return p[15:8];
  endfunction : scale

  function automatic logic [7:0] clamp(input logic [7:0] v);
    return (v < flo) ? flo : ((v > cei) ? cei : v);
  endfunction : clamp

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask : cyc

  task automatic drive(input logic [7:0] dv, input logic [7:0] av);
    @(posedge clk_sys_in);
    duty <= dv;
    amb <= av;
  endtask : drive

  task automatic xfer(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] dat);
    i_lds_host_model.bus_start();
    i_lds_host_model.bus_byte({adr, 1'b0}, rd, ak[2]);
    i_lds_host_model.bus_byte(cmd, rd, ak[1]);
    i_lds_host_model.bus_byte(dat, rd, ak[0]);
    i_lds_host_model.bus_stop();
    cyc(20);
  endtask : xfer

  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    xfer(SLAVE_ADDR, cmd, dat);
    `CHK(ak, 3'b111)
  endtask : wr

  task automatic rd_reg(input logic [7:0] cmd);
    i_lds_host_model.bus_start();
    i_lds_host_model.bus_byte({SLAVE_ADDR, 1'b0}, rd, ak[2]);
    i_lds_host_model.bus_byte(cmd, rd, ak[1]);
    i_lds_host_model.bus_start();
    i_lds_host_model.bus_byte({SLAVE_ADDR, 1'b1}, rd, ak[0]);
    i_lds_host_model.bus_byte(8'hFF, rd, r);
    i_lds_host_model.bus_stop();
    `CHK(ak, 3'b111)
    cyc(4);
  endtask : rd_reg

  task automatic close_out();
    if (n_errors == 0 && compares > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  initial
  begin
    #4000000;
    n_errors++;
    close_out();
  end

  initial
  begin
    cyc(6);
    rst_b_in <= 1'b1;
    lamps <= 1'($random(seed));
    a = 8'($random(seed)) | 8'h80;
    d = 8'($random(seed));
    b = 8'($random(seed));
    drive(8'hFF, a);
    cyc(20);
    `CHK(bri_out, scale(BRI_RST, 8'hFF))
    rv = '{BRI_RST, CTRL_RST, {4'h0, lamps, 3'h0}, {5'h13, 3'h5}, a, FLOOR_RST, CEIL_RST};
    for (int i = 0; i < 7; i++)
    begin
      rd_reg(8'(i));
      `CHK(rd, rv[i])
    end
    flo = 8'($random(seed)) & 8'h3F;
    cei = 8'($random(seed)) | 8'hC0;
    wr(8'h05, flo);
    wr(8'h06, cei);
    rd_reg(8'h05);
    `CHK(rd, flo)
    for (int i = 0; i < 4; i++)
    begin
      xfer(SLAVE_ADDR ^ 7'(7'h01 << i), 8'h01, 8'h01);
      `CHK({ak, en_out}, 4'h0)
      `CHK(dut_oe, 1'b0)
      xfer(SLAVE_ADDR, (i == 0) ? 8'h07 : (8'($random(seed)) | 8'h08), 8'h01);
      `CHK({ak[2:1], en_out}, 3'b100)
    end
    wr(8'h01, 8'hC1);
    `CHK(en_out, 1'b1)
    `CHK(supply_out, 1'b1)
    rd_reg(8'h01);
    `CHK(rd, 8'h01)
    for (int i = 2; i < 5; i++)
    begin
      wr(8'(i), ~rv[i]);
      rd_reg(8'(i));
      `CHK(rd, rv[i])
    end
    @(posedge clk_sys_in);
    fault <= 1'b1;
    ovc <= 1'b1;
    cyc(2);
    fault <= 1'b0;
    ovc <= 1'b0;
    rd_reg(8'h02);
    `CHK(rd, {4'h0, lamps, 3'h5})
    // Hold the finished write open to see that nothing commits before the stop.
    i_lds_host_model.bus_start();
    i_lds_host_model.bus_byte({SLAVE_ADDR, 1'b0}, rd, ak[2]);
    i_lds_host_model.bus_byte(8'h01, rd, ak[1]);
    i_lds_host_model.bus_byte(8'h00, rd, ak[0]);
    cyc(40);
    `CHK(en_out, 1'b1)
    i_lds_host_model.bus_stop();
    cyc(20);
    `CHK({en_out, supply_out}, 2'b00)
    rd_reg(8'h02);
    `CHK(rd, {4'h0, lamps, 3'h0})
    i_lds_host_model.bus_start();
    i_lds_host_model.bus_byte({SLAVE_ADDR, 1'b0}, rd, ak[2]);
    i_lds_host_model.bus_byte(8'h05, rd, ak[1]);
    repeat (4) i_lds_host_model.bus_bit(1'b0, r);
    i_lds_host_model.bus_stop();
    i_lds_host_model.bus_start();
    i_lds_host_model.bus_byte({SLAVE_ADDR, 1'b0}, rd, ak[2]);
    i_lds_host_model.bus_byte(8'h06, rd, ak[1]);
    i_lds_host_model.bus_stop();
    i_lds_host_model.bus_start();
    i_lds_host_model.bus_byte({SLAVE_ADDR, 1'b1}, rd, ak[0]);
    i_lds_host_model.bus_byte(8'hFF, rd, r);
    i_lds_host_model.bus_stop();
    `CHK(rd, cei)
    rd_reg(8'h05);
    `CHK(rd, flo)
    drive(d, a);
    wr(8'h01, 8'h05);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, {8{i[0]}});
      `CHK(bri_out, {8{i[0]}})
    end
    wr(8'h00, b);
    `CHK(bri_out, b)
    wr(8'h01, 8'h01);
    `CHK(bri_out, scale(b, d))
    rd_reg(8'h00);
    `CHK(rd, b)
    wr(8'h01, 8'h07);
    `CHK(bri_out, d)
    wr(8'h00, ~b);
    rd_reg(8'h00);
    `CHK(rd, d)
    wr(8'h01, 8'h05);
    `CHK(bri_out, b)
    wr(8'h01, 8'h0D);
    cyc(100);
    `CHK(bri_out, clamp(a))
    rd_reg(8'h00);
    `CHK(rd, clamp(a))
    wr(8'h06, 8'h60);
    cei = 8'h60;
    `CHK(bri_out, clamp(a))
    wr(8'h01, 8'h09);
    `CHK(bri_out, scale(clamp(a), d))
    // Each delay code must hold the old level until just before its last period ends.
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h01, {2'b00, 2'(i), 4'hD});
      b = clamp(amb);
      // New readings lie inside the limits; the first differs from the last one in bit 7, each later one in bit 4.
      drive(d, {3'b010, 1'(i), 4'($random(seed))});
      cyc(nper[i] * PER - 3);
      `CHK(bri_out, b)
      cyc(8);
      `CHK(bri_out, clamp(amb))
    end
    close_out();
  end
endmodule : lds_slave_regs_tb_top
